// ---- sim/serial_host_model.sv ----
// behavioural two-wire host controller for one serial port of the block
module serial_host_model (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // ***********************************************
  // bit, frame and byte tasks
  // ***********************************************
  localparam int Q = 50; // quarter of the 200 ns link period
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // data moves a quarter into the low phase; the low phase spans three quarters because
  // the device drives its answer about five core clocks after a fall, and an answer
  // landing while the clock is high would look like a start or stop to the device.
  // the bench runs this link far above the host limit only to keep runs short
  task automatic bit_xfer(input logic b, output logic s);
    sda_low = ~b;
    #(2*Q) scl = 1'b1;
    #(Q-5) s = sda;
    #5 scl = 1'b0;
    #Q;
  endtask
  // data falls while the clock is high
  task automatic start_cond();
    sda_low = 1'b1;
    #(2*Q) scl = 1'b0;
    #Q;
  endtask
  // data rises while the clock is high; clock then stands still
  task automatic stop_cond();
    sda_low = 1'b1;
    #Q scl = 1'b1;
    #(2*Q) sda_low = 1'b0;
    #(4*Q);
  endtask
  // msb first, then a released ninth bit for the device's acknowledge
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], s);
    bit_xfer(1'b1, s);
    ack = ~s;
  endtask
  task automatic get_byte(input logic ack_it, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
    bit_xfer(~ack_it, s);
  endtask
endmodule // serial_host_model

// ---- sim/tb_top.sv ----
// self-checking bench: both serial ports, address strap and interrupt
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst, strap, irq_hi, irq_clr, irq_pin, wr_valid, taken;
  logic c_scl, c_low, c_sda, c_o, c_oe_n, r_scl, r_low, r_sda, r_o, r_oe_n;
  logic [7:0] wr_sub, wr_dat, rb_byte, sd_st, cp_st, last_sub, last_dat;
  logic [15:0] mask;
  int mismatches = 0;
  int checks_done = 0;
  int wr_cnt = 0;
  // open-drain lines with pull-ups
  assign c_sda = ~c_low & (c_oe_n | c_o);
  assign r_sda = ~r_low & (r_oe_n | r_o);
  serial_host_model host_c (.scl(c_scl), .sda_low(c_low), .sda(c_sda));
  serial_host_model host_r (.scl(r_scl), .sda_low(r_low), .sda(r_sda));
  dual_host_port_ctrl dut_u (.core_clk(core_clk), .rst(rst), .address_strap_pin(strap),
    .ctrl_port_clock(c_scl), .ctrl_port_data_i(c_sda), .ctrl_port_data_o(c_o),
    .ctrl_port_data_oe_n(c_oe_n), .blanking_readback_clock(r_scl),
    .blanking_readback_data_i(r_sda), .blanking_readback_data_o(r_o),
    .blanking_readback_data_oe_n(r_oe_n), .ctrl_wr_valid(wr_valid),
    .ctrl_wr_subaddr(wr_sub), .ctrl_wr_data(wr_dat), .readback_byte(rb_byte),
    .readback_byte_taken(taken), .std_def_processor_status(sd_st),
    .component_processor_status(cp_st), .irq_event_mask(mask),
    .irq_active_high(irq_hi), .irq_clear(irq_clr), .irq_pin(irq_pin));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // capture completed writes mid-cycle, where the one-cycle pulses stand settled;
  // present a fresh readback byte once one is taken
  always @(negedge core_clk) begin
    if (wr_valid === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
      last_sub <= wr_sub;
      last_dat <= wr_dat;
    end
    if (taken === 1'b1) rb_byte <= rb_byte + 8'h11;
  end
  // ***********************************************
  // compare, verdict and scenarios
  // ***********************************************
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // a refused address must leave the write count untouched
  task automatic ctrl_write(input logic [7:0] dev, sub, dat, input logic ok);
    logic a;
    int n;
    n = wr_cnt + (ok ? 1 : 0);
    host_c.start_cond();
    host_c.put_byte(dev, a);
    check("ctrl address ack", {7'h00, ok}, {7'h00, a});
    if (a === 1'b1) begin
      host_c.put_byte(sub, a);
      check("subaddress ack", 8'h01, {7'h00, a});
      host_c.put_byte(dat, a);
      check("data ack", 8'h01, {7'h00, a});
    end
    host_c.stop_cond();
    check("write count", 8'(n), 8'(wr_cnt));
    if (ok) check("subaddress", sub, last_sub);
    if (ok) check("data", dat, last_dat);
  endtask
  // burst: each data byte after the first lands one register further on
  task automatic ctrl_burst(input logic [7:0] sub, d0, d1);
    logic a;
    int n;
    n = wr_cnt + 2;
    host_c.start_cond();
    host_c.put_byte(8'h40, a);
    host_c.put_byte(sub, a);
    host_c.put_byte(d0, a);
    host_c.put_byte(d1, a);
    check("burst last ack", 8'h01, {7'h00, a});
    host_c.stop_cond();
    check("burst count", 8'(n), 8'(wr_cnt));
    check("burst subaddress", sub + 8'h01, last_sub);
    check("burst data", d1, last_dat);
  endtask
  // two bytes: host acks the first and refuses the second
  task automatic rb_read(input logic [7:0] dev, input logic ok);
    logic a;
    logic [7:0] e, d;
    e = rb_byte;
    host_r.start_cond();
    host_r.put_byte(dev, a);
    check("readback address ack", {7'h00, ok}, {7'h00, a});
    if (a === 1'b1) begin
      host_r.get_byte(1'b1, d);
      check("readback first", e, d);
      host_r.get_byte(1'b0, d);
      check("readback second", e + 8'h11, d);
    end
    host_r.stop_cond();
  endtask
  task automatic t_addresses();
    logic [7:0] cw[2];
    logic [7:0] rr[2];
    cw = '{8'h40, 8'h42};
    rr = '{8'h21, 8'h23};
    for (int s = 0; s < 2; s++) begin
      strap = s[0];
      repeat (10) @(negedge core_clk);
      ctrl_write(cw[s], 8'h10, 8'ha5, 1'b1);
      ctrl_write(cw[1-s], 8'h11, 8'h5a, 1'b0);
      ctrl_write(cw[s] | 8'h01, 8'h12, 8'h00, 1'b0);
      rb_read(rr[s], 1'b1);
      rb_read(rr[1-s], 1'b0);
      rb_read(rr[s] & 8'hfe, 1'b0);
    end
  endtask
  task automatic settle_and_check(input string what, input logic lvl);
    repeat (3) @(negedge core_clk);
    check(what, {7'h00, lvl}, {7'h00, irq_pin});
  endtask
  task automatic t_irq();
    for (int p = 0; p < 2; p++) begin
      irq_hi = p[0];
      mask = 16'h0001;
      settle_and_check("irq idle", ~p[0]);
      cp_st[0] = ~cp_st[0];
      settle_and_check("irq unselected", ~p[0]);
      sd_st[0] = ~sd_st[0];
      settle_and_check("irq std def", p[0]);
      irq_clr = 1'b1;
      @(negedge core_clk) irq_clr = 1'b0;
      settle_and_check("irq cleared", ~p[0]);
      mask = 16'h0100;
      cp_st[0] = ~cp_st[0];
      settle_and_check("irq component", p[0]);
      irq_clr = 1'b1;
      @(negedge core_clk) irq_clr = 1'b0;
    end
  endtask
  initial begin
    {rst, strap, irq_hi, irq_clr, sd_st, cp_st, mask, rb_byte} = {4'h8, 32'h0, 8'h3c};
    repeat (12) @(negedge core_clk);
    rst = 1'b0;
    repeat (8) @(negedge core_clk);
    check("ctrl idle oe_n", 8'h01, {7'h00, c_oe_n});
    check("readback idle oe_n", 8'h01, {7'h00, r_oe_n});
    check("irq after reset", 8'h01, {7'h00, irq_pin});
    ctrl_write(8'h40, 8'h0e, 8'h80, 1'b1);
    ctrl_write(8'h40, 8'h54, 8'h00, 1'b1);
    ctrl_write(8'h40, 8'h0e, 8'h00, 1'b1);
    ctrl_burst(8'h20, 8'h11, 8'h22);
    t_addresses();
    t_irq();
    conclude();
  end
  // roughly seven times the expected run
  initial begin
    #500000;
    mismatches++;
    $display("unexpected watchdog: expected done, seen hang");
    conclude();
  end
endmodule // tb_top

// ---- src/dual_host_port_ctrl.sv ----
// two serial host ports, address strap and status-change interrupt of the decoder
module dual_host_port_ctrl #(
  parameter int STATUS_W = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic address_strap_pin,
  input wire logic ctrl_port_clock,
  input wire logic ctrl_port_data_i,
  output logic ctrl_port_data_o,
  output logic ctrl_port_data_oe_n,
  input wire logic blanking_readback_clock,
  input wire logic blanking_readback_data_i,
  output logic blanking_readback_data_o,
  output logic blanking_readback_data_oe_n,
  output logic ctrl_wr_valid,
  output logic [7:0] ctrl_wr_subaddr,
  output logic [7:0] ctrl_wr_data,
  input wire logic [7:0] readback_byte,
  output logic readback_byte_taken,
  input wire logic [STATUS_W-1:0] std_def_processor_status,
  input wire logic [STATUS_W-1:0] component_processor_status,
  input wire logic [2*STATUS_W-1:0] irq_event_mask,
  input wire logic irq_active_high,
  input wire logic irq_clear,
  output logic irq_pin
);

  // expected first byte of a port for the given strap level
  function automatic logic [7:0] dev_addr(input logic rb_port, input logic strap);
    if (rb_port) begin
      dev_addr = strap ? host_port_pkg::RB_RD_ADDR_HI : host_port_pkg::RB_RD_ADDR_LO;
    end else begin
      dev_addr = strap ? host_port_pkg::CTRL_WR_ADDR_HI : host_port_pkg::CTRL_WR_ADDR_LO;
    end
  endfunction

  // ***********************************************
  // pin synchronisers
  // ***********************************************
  logic [4:0] pin_raw;
  logic [4:0] pin_s1_r;
  logic [4:0] pin_s2_r;
  logic [4:0] pin_s3_r;
  logic [4:0] pin_f_r;
  logic [4:0] pin_prev_r;

  assign pin_raw = {blanking_readback_data_i, blanking_readback_clock, ctrl_port_data_i,
                    ctrl_port_clock, address_strap_pin};

  // three stages; a level counts only once stages two and three agree, filtering glitches
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_s1_r <= host_port_pkg::PIN_RST;
      pin_s2_r <= host_port_pkg::PIN_RST;
      pin_s3_r <= host_port_pkg::PIN_RST;
      pin_f_r <= host_port_pkg::PIN_RST;
      pin_prev_r <= host_port_pkg::PIN_RST;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_f_r <= (pin_s3_r & ~(pin_s2_r ^ pin_s3_r)) | (pin_f_r & (pin_s2_r ^ pin_s3_r));
      pin_prev_r <= pin_f_r;
    end
  end

  logic strap;
  assign strap = pin_f_r[host_port_pkg::PIN_STRAP];

  // ***********************************************
  // byte engines, port 0 control writes, port 1 readback
  // ***********************************************
  host_port_pkg::port_state_t st_r [2];
  logic [3:0] cnt_r [2];
  logic [7:0] sh_r [2];
  logic drv_r [2];
  logic [1:0] scl_rise;
  logic [1:0] scl_fall;
  logic [1:0] start_ev;
  logic [1:0] stop_ev;
  logic [1:0] sda_v;
  logic byte_idx_r;
  logic [7:0] subaddr_r;

  for (genvar p = 0; p < 2; p++) begin : g_port
    localparam int SCL = host_port_pkg::PIN_SCL0 + 2 * p;
    localparam int SDA = SCL + 1;
    logic scl_hi;
    assign scl_hi = pin_f_r[SCL] & pin_prev_r[SCL];
    assign sda_v[p] = pin_f_r[SDA];
    assign scl_rise[p] = pin_f_r[SCL] & ~pin_prev_r[SCL];
    assign scl_fall[p] = ~pin_f_r[SCL] & pin_prev_r[SCL];
    // data moving while the clock stays high frames a transfer
    assign start_ev[p] = scl_hi & pin_prev_r[SDA] & ~pin_f_r[SDA];
    assign stop_ev[p] = scl_hi & ~pin_prev_r[SDA] & pin_f_r[SDA];

    // each port runs its own engine, so traffic on one never disturbs the other
    always_ff @(posedge core_clk) begin
      if (rst) begin
        st_r[p] <= host_port_pkg::ST_IDLE;
        cnt_r[p] <= host_port_pkg::CNT_RST;
        sh_r[p] <= host_port_pkg::BYTE_RST;
        drv_r[p] <= 1'b0;
      end else if (start_ev[p]) begin
        st_r[p] <= host_port_pkg::ST_ADDR;
        cnt_r[p] <= host_port_pkg::CNT_RST;
        drv_r[p] <= 1'b0;
      end else if (stop_ev[p]) begin
        st_r[p] <= host_port_pkg::ST_IDLE;
        drv_r[p] <= 1'b0;
      end else if (scl_rise[p]) begin
        unique case (st_r[p])
          host_port_pkg::ST_ADDR, host_port_pkg::ST_RX: begin
            sh_r[p] <= {sh_r[p][6:0], sda_v[p]};
            cnt_r[p] <= cnt_r[p] + 4'h1;
          end
          host_port_pkg::ST_TX: begin
            cnt_r[p] <= cnt_r[p] + 4'h1;
          end
          host_port_pkg::ST_TXACK: begin
            // host ack asks for another byte, nack ends the read
            st_r[p] <= sda_v[p] ? host_port_pkg::ST_IDLE : host_port_pkg::ST_ACK;
          end
          default: begin
          end
        endcase
      end else if (scl_fall[p]) begin
        unique case (st_r[p])
          host_port_pkg::ST_ADDR: begin
            if (cnt_r[p] == host_port_pkg::BITS_PER_BYTE) begin
              // foreign addresses are left unacknowledged
              if (sh_r[p] == dev_addr(p[0], strap)) begin
                st_r[p] <= host_port_pkg::ST_ACK;
                drv_r[p] <= 1'b1;
              end else begin
                st_r[p] <= host_port_pkg::ST_IDLE;
              end
            end
          end
          host_port_pkg::ST_RX: begin
            if (cnt_r[p] == host_port_pkg::BITS_PER_BYTE) begin
              st_r[p] <= host_port_pkg::ST_ACK;
              drv_r[p] <= 1'b1;
            end
          end
          host_port_pkg::ST_ACK: begin
            cnt_r[p] <= host_port_pkg::CNT_RST;
            if (p == 1) begin
              st_r[p] <= host_port_pkg::ST_TX;
              sh_r[p] <= readback_byte;
              drv_r[p] <= ~readback_byte[7];
            end else begin
              st_r[p] <= host_port_pkg::ST_RX;
              drv_r[p] <= 1'b0;
            end
          end
          host_port_pkg::ST_TX: begin
            if (cnt_r[p] == host_port_pkg::BITS_PER_BYTE) begin
              st_r[p] <= host_port_pkg::ST_TXACK;
              drv_r[p] <= 1'b0;
            end else begin
              sh_r[p] <= {sh_r[p][6:0], 1'b0};
              drv_r[p] <= ~sh_r[p][6];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // open drain: only lows are driven, a one releases the line
  assign ctrl_port_data_o = 1'b0;
  assign ctrl_port_data_oe_n = ~drv_r[0];
  assign blanking_readback_data_o = 1'b0;
  assign blanking_readback_data_oe_n = ~drv_r[1];

  // ***********************************************
  // control write assembly
  // ***********************************************
  logic rx_done;
  assign rx_done = scl_fall[0] && !start_ev[0] && !stop_ev[0]
                   && st_r[0] == host_port_pkg::ST_RX
                   && cnt_r[0] == host_port_pkg::BITS_PER_BYTE;

  // first byte is the subaddress, each later byte a data write; the subaddress
  // steps on so a burst fills consecutive registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      byte_idx_r <= 1'b0;
      subaddr_r <= host_port_pkg::BYTE_RST;
      ctrl_wr_valid <= 1'b0;
      ctrl_wr_subaddr <= host_port_pkg::BYTE_RST;
      ctrl_wr_data <= host_port_pkg::BYTE_RST;
    end else begin
      ctrl_wr_valid <= 1'b0;
      if (start_ev[0]) begin
        byte_idx_r <= 1'b0;
      end else if (rx_done) begin
        byte_idx_r <= 1'b1;
        if (!byte_idx_r) begin
          subaddr_r <= sh_r[0];
        end else begin
          ctrl_wr_valid <= 1'b1;
          ctrl_wr_subaddr <= subaddr_r;
          ctrl_wr_data <= sh_r[0];
          subaddr_r <= subaddr_r + 8'h01;
        end
      end
    end
  end

  // readback consumer advances once per byte loaded for sending
  always_ff @(posedge core_clk) begin
    if (rst) begin
      readback_byte_taken <= 1'b0;
    end else begin
      readback_byte_taken <= scl_fall[1] && !start_ev[1] && !stop_ev[1]
                             && st_r[1] == host_port_pkg::ST_ACK;
    end
  end

  // ***********************************************
  // status-change interrupt
  // ***********************************************
  logic [2*STATUS_W-1:0] status_vec;
  logic [2*STATUS_W-1:0] status_prev_r;
  logic [2*STATUS_W-1:0] status_evt;
  logic irq_pending_r;
  logic irq_pending_nxt;

  assign status_vec = {component_processor_status, std_def_processor_status};
  assign status_evt = (status_vec ^ status_prev_r) & irq_event_mask;
  // a new event wins over a clear in the same cycle
  assign irq_pending_nxt = (|status_evt) | (irq_pending_r & ~irq_clear);

  // pin level is registered so the selected polarity never glitches
  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_prev_r <= '0;
      irq_pending_r <= 1'b0;
      irq_pin <= ~irq_active_high;
    end else begin
      status_prev_r <= status_vec;
      irq_pending_r <= irq_pending_nxt;
      irq_pin <= irq_active_high ? irq_pending_nxt : ~irq_pending_nxt;
    end
  end

  // ***********************************************
  // checks
  // ***********************************************
  sequence s_addr_done(int p);
    scl_fall[p] && !start_ev[p] && !stop_ev[p] && st_r[p] == host_port_pkg::ST_ADDR
      && cnt_r[p] == host_port_pkg::BITS_PER_BYTE;
  endsequence

  property p_addr_low;
    @(posedge core_clk) disable iff (rst)
      (s_addr_done(0) ##0 (!strap && sh_r[0] == 8'h40)) |=> !ctrl_port_data_oe_n;
  endproperty
  a_addr_low: assert property (p_addr_low) else $error("control address 0x40 not acked");

  property p_addr_high;
    @(posedge core_clk) disable iff (rst)
      (s_addr_done(1) ##0 strap) |=> (!blanking_readback_data_oe_n == (sh_r[1] == 8'h23));
  endproperty
  a_addr_high: assert property (p_addr_high) else $error("readback address ack wrong");

  property p_ports_apart;
    @(posedge core_clk) disable iff (rst)
      ctrl_wr_valid |-> $past(st_r[0]) == host_port_pkg::ST_RX;
  endproperty
  a_ports_apart: assert property (p_ports_apart) else $error("write not from control port");

  property p_irq_level;
    @(posedge core_clk) disable iff (rst)
      irq_pending_r |-> irq_pin == irq_active_high;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level ignores polarity");

  property p_irq_on_change;
    @(posedge core_clk) disable iff (rst)
      (|status_evt) |=> irq_pending_r && irq_pin == irq_active_high;
  endproperty
  a_irq_on_change: assert property (p_irq_on_change) else $error("status change no irq");

  property p_irq_masked;
    @(posedge core_clk) disable iff (rst)
      (!irq_pending_r && ((status_vec ^ status_prev_r) & irq_event_mask) == '0)
        |=> !irq_pending_r;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("masked event raised irq");

  property p_write_shape;
    @(posedge core_clk) disable iff (rst)
      ctrl_wr_valid |-> $past(byte_idx_r) && ctrl_wr_data == $past(sh_r[0]);
  endproperty
  a_write_shape: assert property (p_write_shape) else $error("write before subaddress");

endmodule // dual_host_port_ctrl

// ---- src/host_port_pkg.sv ----
// shared constants and types of the dual serial host port block
package host_port_pkg;

  // ***********************************************
  // device addresses, full first byte including direction bit
  // ***********************************************
  localparam logic [7:0] CTRL_WR_ADDR_LO = 8'h40;
  localparam logic [7:0] CTRL_WR_ADDR_HI = 8'h42;
  localparam logic [7:0] RB_RD_ADDR_LO = 8'h21;
  localparam logic [7:0] RB_RD_ADDR_HI = 8'h23;

  // ***********************************************
  // link timing, host side limits and counts
  // ***********************************************
  localparam int CORE_CLK_HZ = 40000000;
  localparam int SCL_MAX_HZ = 400000;
  localparam int SCL_MIN_PERIOD_CYC = CORE_CLK_HZ / SCL_MAX_HZ;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ***********************************************
  // pin sample vector layout and reset values
  // ***********************************************
  localparam int PIN_STRAP = 0;
  localparam int PIN_SCL0 = 1;
  localparam int NUM_PINS = 5;
  localparam logic [4:0] PIN_RST = 5'h1e;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [3:0] CNT_RST = 4'h0;

  // byte engine states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_ACK = 6'h04,
    ST_RX = 6'h08,
    ST_TX = 6'h10,
    ST_TXACK = 6'h20
  } port_state_t;

endpackage
